// ### src/ccpcm_pkg.sv
// Constants, register map and carrier types of the compare channel.
// Assumes an 8-bit register port with a 3-bit word address.
package ccpcm_pkg;

    // Register word addresses
    localparam logic [2:0] REG_CONTROL = 3'h0;
    localparam logic [2:0] REG_CMP_LO = 3'h1;
    localparam logic [2:0] REG_CMP_HI = 3'h2;
    localparam logic [2:0] REG_STATUS = 3'h3;
    localparam logic [2:0] REG_INT_CLEAR = 3'h4;
    localparam logic [2:0] REG_INT_ENABLE = 3'h5;
    localparam logic [2:0] REG_TIMER_LO = 3'h6;
    localparam logic [2:0] REG_TIMER_HI = 3'h7;

    // Values after reset
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [2:0] STATUS_RST = 3'h0;
    localparam logic [2:0] ENABLE_RST = 3'h0;
    localparam logic [7:0] RDATA_RST = 8'h00;

    // Field positions in the control register
    localparam int MODE_LSB = 0;
    localparam int MODE_MSB = 3;

    // Field positions in status, clear and enable registers
    localparam int ST_MATCH = 0;
    localparam int ST_TMR_OVF = 1;
    localparam int ST_SEV = 2;
    localparam int ST_LATCH = 4;
    localparam int ST_PENDING = 5;

    // Mode select codes
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_SET = 4'h8;
    localparam logic [3:0] MODE_CLEAR = 4'h9;
    localparam logic [3:0] MODE_SOFT_INT = 4'hA;
    localparam logic [3:0] MODE_SPECIAL = 4'hB;

    // This instance is the channel that may start a conversion
    localparam logic HAS_ADC_TRIGGER = 1'b1;

    // Pending timer reset after a special event match
    typedef enum logic [0:0] {
        SEV_IDLE = 1'b0,
        SEV_PENDING = 1'b1
    } ccpcm_sev_state_t;

    // One register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } ccpcm_bus_req_t;

    // One output pin: level and enable
    typedef struct packed {
        logic out;
        logic oe;
    } ccpcm_pin_t;

    // Modes in which the channel owns its pin
    function automatic logic ccpcm_mode_drives_pin(input logic [3:0] mode);
        return (mode == MODE_TOGGLE) || (mode == MODE_SET) || (mode == MODE_CLEAR);
    endfunction

endpackage

// ### src/ccpcm_match.sv
// Equality detector between compare value and timer count.
// Assumes both inputs are synchronous to mclk.
`timescale 1ns/1ps
module ccpcm_match (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [15:0] timer_count,
    input wire logic [15:0] compare_value,
    input wire logic sleep_mode,
    output logic match_pulse
);

    logic equal_now;
    logic equal_q;
    logic equal_d;

    // Full 16-bit compare each cycle
    assign equal_now = (timer_count == compare_value);

    // A slow timer rests on the value many cycles; act once per arrival
    assign match_pulse = equal_now && !equal_q && !sleep_mode; // see [R1] see [R17]

    always_comb begin
        equal_d = equal_q;
        if (!sleep_mode) begin
            equal_d = equal_now; // Frozen while the clock would be stopped
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            equal_q <= 1'b0;
        end else begin
            equal_q <= equal_d;
        end
    end

endmodule // ccpcm_match

// ### src/ccpcm_latch.sv
// Compare output latch and pin routing.
// Assumes mode and control writes come from the register file of the top.
`timescale 1ns/1ps
module ccpcm_latch (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [3:0] mode,
    input wire logic ctrl_wr,
    input wire logic [3:0] ctrl_new_mode,
    input wire logic match_pulse,
    input wire logic route_select,
    output logic latch_level,
    output ccpcm_pkg::ccpcm_pin_t pin_primary,
    output ccpcm_pkg::ccpcm_pin_t pin_alternate
);

    logic latch_q;
    logic latch_d;
    ccpcm_pkg::ccpcm_pin_t pri_q;
    ccpcm_pkg::ccpcm_pin_t pri_d;
    ccpcm_pkg::ccpcm_pin_t alt_q;
    ccpcm_pkg::ccpcm_pin_t alt_d;
    logic drive;

    // Latch update; a control write wins over a match in the same cycle
    always_comb begin
        latch_d = latch_q;
        if (ctrl_wr) begin
            case (ctrl_new_mode)
                ccpcm_pkg::MODE_OFF: latch_d = 1'b0; // see [R8]
                ccpcm_pkg::MODE_SET: latch_d = 1'b0;
                ccpcm_pkg::MODE_CLEAR: latch_d = 1'b1;
                default: latch_d = latch_q;
            endcase
        end else if (match_pulse) begin
            case (mode)
                ccpcm_pkg::MODE_TOGGLE: latch_d = !latch_q; // see [R2]
                ccpcm_pkg::MODE_SET: latch_d = 1'b1; // see [R2]
                ccpcm_pkg::MODE_CLEAR: latch_d = 1'b0; // see [R2]
                default: latch_d = latch_q;
            endcase
        end
    end

    // Pin routing; event-only modes release the pin entirely
    always_comb begin
        drive = ccpcm_pkg::ccpcm_mode_drives_pin(mode); // see [R11] see [R14] see [R6]
        pri_d.out = latch_q && !route_select; // see [R7]
        pri_d.oe = drive && !route_select; // see [R7]
        alt_d.out = latch_q && route_select;
        alt_d.oe = drive && route_select;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            latch_q <= 1'b0;
            pri_q <= '0;
            alt_q <= '0;
        end else begin
            latch_q <= latch_d;
            pri_q <= pri_d;
            alt_q <= alt_d;
        end
    end

    assign latch_level = latch_q;
    assign pin_primary = pri_q;
    assign pin_alternate = alt_q;

endmodule // ccpcm_latch

// ### src/ccpcm_top.sv
// Compare channel: register file, match handling, special event trigger,
// interrupt status and converter start.
// How it works
// [R1] Compare value and timer count are compared every cycle; equality sets the match flag in every mode except off.
// [R2] Mode select field picks toggle, set, clear or event-only action on a match.
// [R3] A special event trigger clears the associated timer count to zero.
// [R4] That clear never sets the timer overflow flag; only real overflows do.
// [R5] Channel five's special event also starts a conversion, only while converter is on.
// [R6] Software makes the pin an output through its direction bit first; here the pin enable follows the mode alone, with no direction bit.
// [R7] Route select bit chooses which of two pins carries the output.
// [R8] Writing zero to the control register forces the output latch low.
// [R9] Timer must run in timer or synchronized counter mode during compare.
// [R10] Timer is clocked from instruction clock or external source, not system clock.
// [R11] Mode 1010 raises only the event and leaves the pin undriven.
// [R12] Mode 1011 sets the match flag right on the match.
// [R13] Timer clear waits for the next timer clock edge after the match.
// [R14] Special event mode never drives the channel pin.
// [R15] Rewriting the compare value before the pending clear cancels it.
// [R16] Special event mode makes the compare value a programmable timer period.
// [R17] No matches are detected or acted on while asleep.
// [R18] Match flag stays set until software clears it.
// Assumes an external 16-bit timer that gives its count, a one-cycle pulse per
// timer clock rising edge and a one-cycle pulse per genuine overflow.
`timescale 1ns/1ps
module ccpcm_top (
    input wire logic mclk,
    input wire logic srst,
    input wire ccpcm_pkg::ccpcm_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic timer_overflow,
    output logic timer_clear,
    input wire logic converter_on_bit,
    output logic conversion_go,
    input wire logic output_pin_route_select,
    input wire logic sleep_mode,
    output ccpcm_pkg::ccpcm_pin_t pin_primary,
    output ccpcm_pkg::ccpcm_pin_t pin_alternate,
    output logic irq
);

    // Register state
    logic [7:0] control_q;
    logic [7:0] control_d;
    logic [15:0] cmp_q;
    logic [15:0] cmp_d;
    logic [2:0] status_q;
    logic [2:0] status_d;
    logic [2:0] enable_q;
    logic [2:0] enable_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    // Trigger state
    ccpcm_pkg::ccpcm_sev_state_t sev_q;
    ccpcm_pkg::ccpcm_sev_state_t sev_d;
    logic go_q;
    logic go_d;

    // Decoded strobes
    logic wr_control;
    logic wr_cmp;
    logic wr_clear;
    logic [3:0] mode;
    logic match_pulse;
    logic latch_level;
    logic special_match;
    logic clear_now;
    logic [2:0] events;

    assign mode = control_q[ccpcm_pkg::MODE_MSB:ccpcm_pkg::MODE_LSB];
    assign wr_control = bus_req.wr && (bus_req.addr == ccpcm_pkg::REG_CONTROL);
    assign wr_cmp = bus_req.wr && ((bus_req.addr == ccpcm_pkg::REG_CMP_LO) ||
        (bus_req.addr == ccpcm_pkg::REG_CMP_HI));
    assign wr_clear = bus_req.wr && (bus_req.addr == ccpcm_pkg::REG_INT_CLEAR);

    // Equality detection
    ccpcm_match u_match (
        .mclk(mclk),
        .srst(srst),
        .timer_count(timer_count),
        .compare_value(cmp_q),
        .sleep_mode(sleep_mode),
        .match_pulse(match_pulse)
    );

    // Output latch and pin drive
    ccpcm_latch u_latch (
        .mclk(mclk),
        .srst(srst),
        .mode(mode),
        .ctrl_wr(wr_control),
        .ctrl_new_mode(bus_req.wdata[ccpcm_pkg::MODE_MSB:ccpcm_pkg::MODE_LSB]),
        .match_pulse(match_pulse),
        .route_select(output_pin_route_select),
        .latch_level(latch_level),
        .pin_primary(pin_primary),
        .pin_alternate(pin_alternate)
    );

    // A match counts as a special event only in special event mode
    assign special_match = match_pulse && (mode == ccpcm_pkg::MODE_SPECIAL); // see [R12]

    // Control and compare value registers
    always_comb begin
        control_d = control_q;
        cmp_d = cmp_q;
        enable_d = enable_q;
        if (wr_control) begin
            control_d = bus_req.wdata; // Upper bits kept for other channel modes
        end
        if (bus_req.wr && (bus_req.addr == ccpcm_pkg::REG_CMP_LO)) begin
            cmp_d[7:0] = bus_req.wdata;
        end
        if (bus_req.wr && (bus_req.addr == ccpcm_pkg::REG_CMP_HI)) begin
            cmp_d[15:8] = bus_req.wdata;
        end
        if (bus_req.wr && (bus_req.addr == ccpcm_pkg::REG_INT_ENABLE)) begin
            enable_d = bus_req.wdata[2:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            control_q <= ccpcm_pkg::CONTROL_RST;
            cmp_q <= ccpcm_pkg::CMP_RST;
            enable_q <= ccpcm_pkg::ENABLE_RST;
        end else begin
            control_q <= control_d;
            cmp_q <= cmp_d;
            enable_q <= enable_d;
        end
    end

    // Pending reset waits for a timer edge strictly after the match
    always_comb begin
        sev_d = sev_q;
        clear_now = 1'b0;
        case (sev_q)
            ccpcm_pkg::SEV_IDLE: begin
                if (special_match) begin
                    sev_d = ccpcm_pkg::SEV_PENDING; // see [R13]
                end
            end
            ccpcm_pkg::SEV_PENDING: begin
                if (wr_cmp || (mode != ccpcm_pkg::MODE_SPECIAL)) begin
                    sev_d = ccpcm_pkg::SEV_IDLE; // see [R15]
                end else if (timer_tick) begin
                    clear_now = 1'b1; // see [R3] see [R13] see [R16]
                    sev_d = ccpcm_pkg::SEV_IDLE;
                end
            end
            default: sev_d = ccpcm_pkg::SEV_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            sev_q <= ccpcm_pkg::SEV_IDLE;
        end else begin
            sev_q <= sev_d;
        end
    end

    // Combinational so the timer applies the clear on this very tick
    assign timer_clear = clear_now;

    // Converter start, only when the converter is switched on
    always_comb begin
        go_d = special_match && ccpcm_pkg::HAS_ADC_TRIGGER && converter_on_bit; // see [R5]
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            go_q <= 1'b0;
        end else begin
            go_q <= go_d;
        end
    end

    assign conversion_go = go_q;

    // Sticky events; a set in the clearing cycle survives
    always_comb begin
        events = 3'h0;
        events[ccpcm_pkg::ST_MATCH] = match_pulse && (mode != ccpcm_pkg::MODE_OFF); // see [R1]
        events[ccpcm_pkg::ST_TMR_OVF] = timer_overflow; // see [R4]
        events[ccpcm_pkg::ST_SEV] = special_match;
        status_d = status_q;
        if (wr_clear) begin
            status_d = status_q & ~bus_req.wdata[2:0];
        end
        status_d = status_d | events; // see [R18]
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            status_q <= ccpcm_pkg::STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

    // Level interrupt while any enabled flag is set
    assign irq = |(status_q & enable_q);

    // Read data stand the cycle after the strobe only
    always_comb begin
        rdata_d = ccpcm_pkg::RDATA_RST;
        if (bus_req.rd) begin
            case (bus_req.addr)
                ccpcm_pkg::REG_CONTROL: rdata_d = control_q;
                ccpcm_pkg::REG_CMP_LO: rdata_d = cmp_q[7:0];
                ccpcm_pkg::REG_CMP_HI: rdata_d = cmp_q[15:8];
                ccpcm_pkg::REG_STATUS: begin
                    rdata_d[2:0] = status_q;
                    rdata_d[ccpcm_pkg::ST_LATCH] = latch_level;
                    rdata_d[ccpcm_pkg::ST_PENDING] = (sev_q == ccpcm_pkg::SEV_PENDING);
                end
                ccpcm_pkg::REG_INT_ENABLE: rdata_d[2:0] = enable_q;
                ccpcm_pkg::REG_TIMER_LO: rdata_d = timer_count[7:0];
                ccpcm_pkg::REG_TIMER_HI: rdata_d = timer_count[15:8];
                default: rdata_d = ccpcm_pkg::RDATA_RST; // Clear register reads zero
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q <= ccpcm_pkg::RDATA_RST;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule // ccpcm_top

// ### dv/ccpcm_timer_model.sv
// Behavioural 16-bit timer and converter start counter beside the channel.
// Assumes the system clock mclk; the timer ticks once every DIV cycles.
`timescale 1ns/1ps
module ccpcm_timer_model #(
    parameter int DIV = 4
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic run,
    input wire logic load,
    input wire logic [15:0] load_val,
    input wire logic timer_clear,
    input wire logic conversion_go,
    output logic [15:0] count,
    output logic tick,
    output logic ovf,
    output logic [7:0] conv_cnt
);
    logic [7:0] div_q;

    // Prescaled tick, never the raw system clock
    assign tick = run && (div_q == 8'(DIV - 1));
    // Overflow only on a real wrap, not on a clear
    assign ovf = tick && !timer_clear && (count == 16'hFFFF);

    // Counts in step with mclk, i.e. synchronized mode
    always_ff @(posedge mclk) begin
        if (srst) begin
            div_q <= 8'h00;
            count <= 16'h0000;
            conv_cnt <= 8'h00;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            conv_cnt <= conv_cnt + {7'h00, conversion_go};
            if (load) begin
                count <= load_val;
            end else if (tick) begin
                count <= timer_clear ? 16'h0000 : count + 16'h0001;
            end
        end
    end
endmodule // ccpcm_timer_model

// ### dv/ccpcm_properties.sv
// Checker on the compare channel ports, bound to ccpcm_top.
// Assumes one clock; mode and compare value are shadowed from bus writes.
`timescale 1ns/1ps
module ccpcm_properties (
    input wire logic mclk,
    input wire logic srst,
    input wire ccpcm_pkg::ccpcm_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic [15:0] timer_count,
    input wire logic timer_tick,
    input wire logic timer_overflow,
    input wire logic timer_clear,
    input wire logic converter_on_bit,
    input wire logic conversion_go,
    input wire logic output_pin_route_select,
    input wire logic sleep_mode,
    input wire ccpcm_pkg::ccpcm_pin_t pin_primary,
    input wire ccpcm_pkg::ccpcm_pin_t pin_alternate,
    input wire logic irq
);
    logic [3:0] mode_q;
    logic [3:0] mode_d;
    logic [15:0] cmp_q;
    logic [15:0] cmp_d;
    logic wr_ctl;

    function automatic logic ev(input logic [3:0] m);
        return m == ccpcm_pkg::MODE_SOFT_INT || m == ccpcm_pkg::MODE_SPECIAL;
    endfunction

    // Shadows; status bits are not visible at the ports
    assign wr_ctl = bus_req.wr && bus_req.addr == ccpcm_pkg::REG_CONTROL;
    always_comb begin
        mode_d = wr_ctl ? bus_req.wdata[3:0] : mode_q;
        cmp_d = cmp_q;
        if (bus_req.wr && bus_req.addr == ccpcm_pkg::REG_CMP_LO) begin
            cmp_d[7:0] = bus_req.wdata;
        end
        if (bus_req.wr && bus_req.addr == ccpcm_pkg::REG_CMP_HI) begin
            cmp_d[15:8] = bus_req.wdata;
        end
    end
    always_ff @(posedge mclk) begin
        mode_q <= srst ? 4'h0 : mode_d;
        cmp_q <= srst ? 16'h0000 : cmp_d;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Control zeroed, then left alone for a cycle
    sequence s_ctl_zero;
        wr_ctl && bus_req.wdata == 8'h00 ##1 !wr_ctl;
    endsequence
    // Fresh arrival at the compare value; a wake-up cycle is left out on purpose
    sequence s_sev_hit;
        mode_q == ccpcm_pkg::MODE_SPECIAL && timer_count == cmp_q && converter_on_bit &&
            !sleep_mode && !$past(sleep_mode) && $past(timer_count) != $past(cmp_q);
    endsequence

    AST_CLEAR_ON_TICK: assert property (timer_clear |-> timer_tick)
        else $error("timer clear outside a timer tick");
    AST_CLEAR_IN_SPECIAL: assert property (timer_clear |->
        mode_q == ccpcm_pkg::MODE_SPECIAL || $past(mode_q) == ccpcm_pkg::MODE_SPECIAL)
        else $error("timer clear outside special event mode");
    AST_GO_ONE_CYCLE: assert property (conversion_go |=> !conversion_go)
        else $error("conversion start longer than one cycle");
    AST_GO_CAUSE: assert property (conversion_go |->
        $past(mode_q) == ccpcm_pkg::MODE_SPECIAL && $past(timer_count) == $past(cmp_q) &&
        $past(converter_on_bit))
        else $error("conversion start without a special event match");
    AST_GO_ON_HIT: assert property (s_sev_hit |=> conversion_go)
        else $error("special event match without a conversion start");
    AST_SLEEP_NO_GO: assert property ($past(sleep_mode) |-> !conversion_go)
        else $error("conversion start while asleep");
    AST_EVENT_NO_PIN: assert property (ev(mode_q) && ev($past(mode_q)) &&
        ev($past(mode_q, 2)) |-> !pin_primary.oe && !pin_alternate.oe)
        else $error("pin driven in an event only mode");
    AST_ZERO_LOW: assert property (s_ctl_zero |=> !pin_primary.out && !pin_alternate.out)
        else $error("output latch not low after control cleared");
    AST_ROUTE_ALT: assert property (pin_alternate.oe |-> $past(output_pin_route_select))
        else $error("alternate pin driven while primary selected");
    AST_ROUTE_PRI: assert property (pin_primary.oe |-> !$past(output_pin_route_select))
        else $error("primary pin driven while alternate selected");
endmodule // ccpcm_properties

bind ccpcm_top ccpcm_properties chk_u (.mclk, .srst, .bus_req, .rdata, .timer_count,
    .timer_tick, .timer_overflow, .timer_clear, .converter_on_bit, .conversion_go,
    .output_pin_route_select, .sleep_mode, .pin_primary, .pin_alternate, .irq);

// ### dv/ccp_compare_mode_tb.sv
// Testbench of the compare channel: register tasks, timer model, bound checker.
// Assumes the timer model ticks every fourth mclk cycle.
`timescale 1ns/1ps
module ccp_compare_mode_tb;
    logic mclk;
    logic srst;
    ccpcm_pkg::ccpcm_bus_req_t bus_req;
    logic [7:0] rdata;
    logic [15:0] timer_count;
    logic timer_tick;
    logic timer_overflow;
    logic timer_clear;
    logic converter_on_bit;
    logic conversion_go;
    logic output_pin_route_select;
    logic sleep_mode;
    ccpcm_pkg::ccpcm_pin_t pin_primary;
    ccpcm_pkg::ccpcm_pin_t pin_alternate;
    logic irq;
    logic run;
    logic load;
    logic [15:0] load_val;
    logic [7:0] conv_cnt;
    logic [7:0] c0;
    logic [15:0] tgt;
    int error_cnt;
    int cmp_count;
    logic [3:0] mode_tab [3];
    logic exp_tab [3];

    ccpcm_top dut_u (.mclk, .srst, .bus_req, .rdata, .timer_count, .timer_tick,
        .timer_overflow, .timer_clear, .converter_on_bit, .conversion_go,
        .output_pin_route_select, .sleep_mode, .pin_primary, .pin_alternate, .irq);
    ccpcm_timer_model #(.DIV(4)) tm_u (.mclk, .srst, .run, .load, .load_val, .timer_clear,
        .conversion_go, .count(timer_count), .tick(timer_tick), .ovf(timer_overflow), .conv_cnt);

    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Requests held one cycle; the next call or an idle replaces them
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        bus_req <= '{a, d, 1'h1, 1'h0};
        @(posedge mclk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
        bus_req <= '{a, 8'h00, 1'h0, 1'h1};
        @(posedge mclk);
        bus_req <= '0;
        #1 chk($sformatf("reg %0d", a), {8'h00, e}, {8'h00, rdata & m});
        @(posedge mclk);
    endtask
    task automatic idle(input int n);
        bus_req <= '0;
        repeat (n) @(posedge mclk);
    endtask
    // Low byte first so the interim value cannot equal the count
    task automatic set_cmp(input logic [15:0] v);
        wr(ccpcm_pkg::REG_CMP_LO, v[7:0]);
        wr(ccpcm_pkg::REG_CMP_HI, v[15:8]);
    endtask
    task automatic wait_for(input logic [15:0] v);
        int n;
        n = 0;
        idle(1);
        while (timer_count !== v && n < 4000) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 4000) chk("timer wait", v, timer_count);
    endtask
    task automatic period(input logic [7:0] e);
        wait_for(16'h0030);
        wait_for(16'h0000);
        idle(2);
        chk("conversions", {8'h00, e}, {8'h00, conv_cnt});
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Watchdog far beyond the expected run of under 1500 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        wrap_up();
    end

    // Main sequence
    initial begin
        bus_req = '0;
        srst = 1'h1;
        {converter_on_bit, output_pin_route_select, sleep_mode, run, load} = 5'h00;
        load_val = 16'h0000;
        error_cnt = 0;
        cmp_count = 0;
        mode_tab = '{ccpcm_pkg::MODE_TOGGLE, ccpcm_pkg::MODE_CLEAR, ccpcm_pkg::MODE_SET};
        exp_tab = '{1'h1, 1'h0, 1'h1};
        repeat (8) @(posedge mclk);
        srst <= 1'h0;
        @(posedge mclk);
        rdc(ccpcm_pkg::REG_STATUS, 8'hFF, 8'h00);
        rdc(ccpcm_pkg::REG_CONTROL, 8'hFF, 8'h00);
        run <= 1'h1;
        wr(ccpcm_pkg::REG_INT_ENABLE, 8'h07);
        // Toggle, clear, set; flag left set across all three matches
        for (int i = 0; i < 3; i++) begin
            wr(ccpcm_pkg::REG_CONTROL, {4'h0, mode_tab[i]});
            // Wait for the match value itself, so the pin has settled when looked at
            tgt = timer_count + 16'h0010;
            set_cmp(tgt);
            wait_for(tgt);
            idle(3);
            chk("pin out", {15'h0, exp_tab[i]}, {15'h0, pin_primary.out});
            chk("pin oe", 16'h0001, {15'h0, pin_primary.oe});
            rdc(ccpcm_pkg::REG_STATUS, 8'h01, 8'h01);
        end
        chk("irq", 16'h0001, {15'h0, irq});
        output_pin_route_select <= 1'h1;
        idle(3);
        chk("alt pin", 16'h0003, {14'h0, pin_alternate});
        chk("pri oe", 16'h0000, {15'h0, pin_primary.oe});
        output_pin_route_select <= 1'h0;
        wr(ccpcm_pkg::REG_CONTROL, 8'h00);
        idle(3);
        rdc(ccpcm_pkg::REG_STATUS, 8'h10, 8'h00);
        chk("pin after zero", 16'h0000, {14'h0, pin_primary});
        // Event only match with the interrupt masked, then unmasked, then cleared
        wr(ccpcm_pkg::REG_CONTROL, {4'h0, ccpcm_pkg::MODE_SOFT_INT});
        wr(ccpcm_pkg::REG_INT_CLEAR, 8'h07);
        wr(ccpcm_pkg::REG_INT_ENABLE, 8'h00);
        tgt = timer_count + 16'h0010;
        set_cmp(tgt);
        wait_for(tgt);
        idle(3);
        rdc(ccpcm_pkg::REG_STATUS, 8'h01, 8'h01);
        chk("masked irq", 16'h0000, {15'h0, irq});
        chk("event pin", 16'h0000, {14'h0, pin_primary});
        wr(ccpcm_pkg::REG_INT_ENABLE, 8'h07);
        idle(2);
        chk("irq", 16'h0001, {15'h0, irq});
        wr(ccpcm_pkg::REG_INT_CLEAR, 8'h07);
        idle(2);
        chk("irq", 16'h0000, {15'h0, irq});
        // Asleep: the count sits on the compare value and no match is taken
        sleep_mode <= 1'h1;
        tgt = timer_count + 16'h0008;
        set_cmp(tgt);
        wait_for(tgt);
        idle(3);
        rdc(ccpcm_pkg::REG_STATUS, 8'h01, 8'h00);
        sleep_mode <= 1'h0;
        // Genuine overflow, then a write to read-only status
        load_val <= 16'hFFF0;
        load <= 1'h1;
        @(posedge mclk);
        load <= 1'h0;
        wait_for(16'h0002);
        rdc(ccpcm_pkg::REG_STATUS, 8'h02, 8'h02);
        wr(ccpcm_pkg::REG_INT_CLEAR, 8'h07);
        wr(ccpcm_pkg::REG_STATUS, 8'h07);
        rdc(ccpcm_pkg::REG_STATUS, 8'h07, 8'h00);
        // Special event at compare value 0x30, a period of 0x31 ticks, converter on then off
        load_val <= 16'h0000;
        load <= 1'h1;
        @(posedge mclk);
        load <= 1'h0;
        set_cmp(16'h0030);
        wr(ccpcm_pkg::REG_CONTROL, {4'h0, ccpcm_pkg::MODE_SPECIAL});
        wr(ccpcm_pkg::REG_INT_CLEAR, 8'h07);
        converter_on_bit <= 1'h1;
        c0 = conv_cnt;
        period(c0 + 8'h01);
        rdc(ccpcm_pkg::REG_STATUS, 8'h07, 8'h05);
        chk("special pin", 16'h0000, {14'h0, pin_primary});
        period(c0 + 8'h02);
        converter_on_bit <= 1'h0;
        period(c0 + 8'h02);
        // Compare rewritten before the pending clear
        wait_for(16'h0030);
        wr(ccpcm_pkg::REG_CMP_LO, 8'hFF);
        idle(40);
        chk("timer kept", 16'h0001, {15'h0, timer_count > 16'h0030});
        rdc(ccpcm_pkg::REG_STATUS, 8'h20, 8'h00);
        rdc(ccpcm_pkg::REG_TIMER_HI, 8'hFF, 8'h00);
        wrap_up();
    end
endmodule // ccp_compare_mode_tb
